/* rtl/branch_cond.sv */
module branch_cond
	import exec_pkg::*;
(
	input wire op_t op,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] flags,
	output logic is_branch,
	output logic taken
);
	// ************************************************************
	// condition select
	// ************************************************************
	always_comb begin
		is_branch = 1'b1;
		taken = 1'b0;
		case (op)
			branch_on_status_bit_one: taken = flags[bit_sel];
			branch_on_status_bit_zero: taken = !flags[bit_sel];
			branch_on_equal: taken = flags[FLAG_Z];
			branch_on_unequal: taken = !flags[FLAG_Z];
			branch_on_carry_one: taken = flags[FLAG_C];
			branch_on_lower: taken = flags[FLAG_C];
			branch_on_carry_zero: taken = !flags[FLAG_C];
			branch_on_same_or_higher: taken = !flags[FLAG_C];
			branch_on_minus: taken = flags[FLAG_N];
			branch_on_plus: taken = !flags[FLAG_N];
			// n xor v, not the stored s flag
			branch_on_signed_ge: taken = !(flags[FLAG_N] ^ flags[FLAG_V]);
			branch_on_signed_lt: taken = flags[FLAG_N] ^ flags[FLAG_V];
			branch_on_half_carry_one: taken = flags[FLAG_H];
			branch_on_half_carry_zero: taken = !flags[FLAG_H];
			branch_on_copy_flag_one: taken = flags[FLAG_T];
			branch_on_copy_flag_zero: taken = !flags[FLAG_T];
			branch_on_overflow_one: taken = flags[FLAG_V];
			branch_on_overflow_zero: taken = !flags[FLAG_V];
			branch_on_irq_enabled: taken = flags[FLAG_I];
			branch_on_irq_disabled: taken = !flags[FLAG_I];
			default: is_branch = 1'b0;
		endcase
	end
endmodule : branch_cond

/* rtl/exec_pkg.sv */
package exec_pkg;
	// ************************************************************
	// sizes
	// ************************************************************
	localparam int DATA_W = 8;
	localparam int PC_W = 16;
	localparam int NUM_GPR = 32;
	localparam int NUM_IO = 64;
	localparam int DISP_W = 7;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] OFS_OP = 8'h00;
	localparam logic [7:0] OFS_SEL = 8'h01;
	localparam logic [7:0] OFS_BIT = 8'h02;
	localparam logic [7:0] OFS_DISP = 8'h03;
	localparam logic [7:0] OFS_PC_LO = 8'h04;
	localparam logic [7:0] OFS_PC_HI = 8'h05;
	localparam logic [7:0] OFS_FLAGS = 8'h06;
	localparam logic [7:0] OFS_STAT = 8'h07;
	localparam logic [7:0] OFS_GPR_BASE = 8'h40;
	localparam logic [7:0] OFS_IO_BASE = 8'h80;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int OP_TWO_WORD_BIT = 7;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_CYC_LSB = 1;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// ************************************************************
	// reset values and cycle counts
	// ************************************************************
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [4:0] {
		skip_on_reg_bit_one,
		skip_on_io_bit_zero,
		skip_on_io_bit_one,
		branch_on_status_bit_one,
		branch_on_status_bit_zero,
		branch_on_equal,
		branch_on_unequal,
		branch_on_carry_one,
		branch_on_carry_zero,
		branch_on_same_or_higher,
		branch_on_lower,
		branch_on_minus,
		branch_on_plus,
		branch_on_signed_ge,
		branch_on_signed_lt,
		branch_on_half_carry_one,
		branch_on_half_carry_zero,
		branch_on_copy_flag_one,
		branch_on_copy_flag_zero,
		branch_on_overflow_one,
		branch_on_overflow_zero,
		branch_on_irq_enabled,
		branch_on_irq_disabled,
		io_bit_force_one,
		io_bit_force_zero,
		shift_left_logical,
		shift_right_logical,
		rotate_left_via_carry,
		rotate_right_via_carry,
		shift_right_arith
	} op_t;

	localparam logic [4:0] OP_LAST = 5'h1d;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic [7:0] value;
		logic [7:0] flags;
	} alu_out_t;
endpackage : exec_pkg

/* rtl/exec_slice.sv */
// What this block does
// - skip next instruction when the chosen general register bit is one.
// - skip next instruction when the chosen I/O bit is zero; no flags.
// - skip next instruction when the chosen I/O bit is one; no flags.
// - status-bit-set branch jumps to pc plus k plus one when bit is one.
// - status-bit-clear branch jumps when bit is zero; one or two cycles.
// - carry branches: set and lower on c one, clear and higher on zero.
// - minus on n one, plus on n zero, signed ge on n xor v zero.
// - half-carry branches on h one or h zero.
// - copy-flag branches on t one or t zero; flags unchanged.
// - overflow branches on v one or zero; one cycle untaken, two taken.
// - interrupt branches on i one or zero; i never changed.
// - io bit force one sets only that bit, two cycles, no flags.
// - io bit force zero clears only that bit, two cycles, no flags.
// - left shifts: zero or carry into bit 0, carry from bit 7.
// - logical and carry right shifts: zero or carry into bit 7, carry from bit 0.
// - arithmetic right shift keeps the sign bit, updates z c n v.
module exec_slice
	import exec_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire bus_req_t req,
	output logic [7:0] rdata,
	output logic busy,
	output logic done
);
	// ************************************************************
	// state
	// ************************************************************
	typedef enum logic {
		idle,
		run
	} state_t;

	state_t state_q;
	op_t op_q;
	logic two_word_q;
	logic [5:0] sel_q;
	logic [2:0] bit_q;
	logic [DISP_W-1:0] disp_q;
	logic [PC_W-1:0] pc_q;
	logic [7:0] flags_q;
	logic [1:0] elapsed_q;
	logic [1:0] last_cyc_q;
	logic [7:0] rdata_q;
	logic done_q;
	logic [7:0] gpr_q [NUM_GPR];
	logic [7:0] io_q [NUM_IO];

	logic start;
	logic legal_op;
	logic finish;
	logic bus_wr_ok;
	logic [7:0] gpr_val;
	logic [7:0] io_val;
	logic is_branch;
	logic br_taken;
	logic is_skip;
	logic skip_taken;
	logic [1:0] needed;
	logic [PC_W-1:0] disp_ext;
	logic [PC_W-1:0] pc_d;
	alu_out_t shift_res;
	logic is_shift;
	logic is_force;

	// ************************************************************
	// operand fetch and leaf units
	// ************************************************************
	assign gpr_val = gpr_q[sel_q[4:0]];
	assign io_val = io_q[sel_q];

	branch_cond u_branch (
		.op(op_q),
		.bit_sel(bit_q),
		.flags(flags_q),
		.is_branch(is_branch),
		.taken(br_taken)
	);

	shift_unit u_shift (
		.op(op_q),
		.value(gpr_val),
		.flags(flags_q),
		.res(shift_res)
	);

	// ************************************************************
	// decode
	// ************************************************************
	// codes past the last op are refused, not run as something else
	assign legal_op = (req.wdata[4:0] <= OP_LAST);
	assign start = req.wr && (req.addr == OFS_OP) && (state_q == idle)
		&& legal_op;
	// operand and state writes are ignored while the slice is running
	assign bus_wr_ok = req.wr && (state_q == idle);

	assign is_skip = (op_q == skip_on_reg_bit_one)
		|| (op_q == skip_on_io_bit_zero) || (op_q == skip_on_io_bit_one);
	assign is_force = (op_q == io_bit_force_one)
		|| (op_q == io_bit_force_zero);
	assign is_shift = !is_skip && !is_branch && !is_force;

	always_comb begin
		skip_taken = 1'b0;
		case (op_q)
			skip_on_reg_bit_one: skip_taken = gpr_val[bit_q];
			skip_on_io_bit_zero: skip_taken = !io_val[bit_q];
			skip_on_io_bit_one: skip_taken = io_val[bit_q];
			default: skip_taken = 1'b0;
		endcase
	end

	// ************************************************************
	// cycle count and next pc
	// ************************************************************
	assign disp_ext = {{(PC_W-DISP_W){disp_q[DISP_W-1]}}, disp_q};

	always_comb begin
		needed = CYC_ONE;
		pc_d = pc_q + 16'h0001;
		if (is_skip && skip_taken) begin
			needed = two_word_q ? CYC_THREE : CYC_TWO;
			pc_d = two_word_q ? pc_q + 16'h0003 : pc_q + 16'h0002;
		end else if (is_branch && br_taken) begin
			needed = CYC_TWO;
			pc_d = pc_q + disp_ext + 16'h0001;
		end else if (is_force) begin
			needed = CYC_TWO;
		end
	end

	assign finish = (state_q == run) && (elapsed_q == needed);

	// ************************************************************
	// sequencer
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= idle;
			elapsed_q <= 2'h0;
		end else if (start) begin
			state_q <= run;
			elapsed_q <= CYC_ONE;
		end else if (finish) begin
			state_q <= idle;
			elapsed_q <= 2'h0;
		end else if (state_q == run) begin
			elapsed_q <= elapsed_q + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			done_q <= 1'b0;
			last_cyc_q <= 2'h0;
		end else begin
			done_q <= finish;
			if (finish) begin
				last_cyc_q <= needed;
			end
		end
	end

	// ************************************************************
	// instruction fields
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			op_q <= skip_on_reg_bit_one;
			two_word_q <= 1'b0;
			sel_q <= 6'h00;
			bit_q <= 3'h0;
			disp_q <= 7'h00;
		end else if (bus_wr_ok) begin
			if (start) begin
				op_q <= op_t'(req.wdata[4:0]);
				two_word_q <= req.wdata[OP_TWO_WORD_BIT];
			end
			if (req.addr == OFS_SEL) begin
				sel_q <= req.wdata[5:0];
			end
			if (req.addr == OFS_BIT) begin
				bit_q <= req.wdata[2:0];
			end
			if (req.addr == OFS_DISP) begin
				disp_q <= req.wdata[DISP_W-1:0];
			end
		end
	end

	// ************************************************************
	// program counter and flags
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			pc_q <= PC_RST;
		end else if (finish) begin
			pc_q <= pc_d;
		end else if (bus_wr_ok && req.addr == OFS_PC_LO) begin
			pc_q[7:0] <= req.wdata;
		end else if (bus_wr_ok && req.addr == OFS_PC_HI) begin
			pc_q[15:8] <= req.wdata;
		end
	end

	// skips, branches and io forces leave the flags as they are
	always_ff @(posedge clk) begin
		if (rst) begin
			flags_q <= FLAGS_RST;
		end else if (finish && is_shift) begin
			flags_q <= shift_res.flags;
		end else if (bus_wr_ok && req.addr == OFS_FLAGS) begin
			flags_q <= req.wdata;
		end
	end

	// ************************************************************
	// general registers
	// ************************************************************
	// no reset: contents are software's to load
	always_ff @(posedge clk) begin
		if (finish && is_shift) begin
			gpr_q[sel_q[4:0]] <= shift_res.value;
		end else if (bus_wr_ok && req.addr[7:5] == OFS_GPR_BASE[7:5]) begin
			gpr_q[req.addr[4:0]] <= req.wdata;
		end
	end

	// ************************************************************
	// io space
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IO; gi++) begin : g_io
			always_ff @(posedge clk) begin
				if (rst) begin
					io_q[gi] <= 8'h00;
				end else if (finish && is_force && sel_q == 6'(gi)) begin
					// read-modify-write of one bit only
					io_q[gi][bit_q] <= (op_q == io_bit_force_one);
				end else if (bus_wr_ok && req.addr[7:6] == OFS_IO_BASE[7:6]
					&& req.addr[5:0] == 6'(gi)) begin
					io_q[gi] <= req.wdata;
				end
			end
		end
	endgenerate

	// ************************************************************
	// read port
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (req.rd) begin
			if (req.addr[7:6] == OFS_IO_BASE[7:6]) begin
				rdata_q <= io_q[req.addr[5:0]];
			end else if (req.addr[7:5] == OFS_GPR_BASE[7:5]) begin
				rdata_q <= gpr_q[req.addr[4:0]];
			end else begin
				unique case (req.addr)
					OFS_OP: rdata_q <= {two_word_q, 2'b00, op_q};
					OFS_SEL: rdata_q <= {2'b00, sel_q};
					OFS_BIT: rdata_q <= {5'h00, bit_q};
					OFS_DISP: rdata_q <= {1'b0, disp_q};
					OFS_PC_LO: rdata_q <= pc_q[7:0];
					OFS_PC_HI: rdata_q <= pc_q[15:8];
					OFS_FLAGS: rdata_q <= flags_q;
					OFS_STAT: rdata_q <= {5'h00, last_cyc_q, state_q == run};
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end

	assign rdata = rdata_q;
	assign busy = (state_q == run);
	assign done = done_q;
endmodule : exec_slice

/* rtl/shift_unit.sv */
module shift_unit
	import exec_pkg::*;
(
	input wire op_t op,
	input wire logic [7:0] value,
	input wire logic [7:0] flags,
	output alu_out_t res
);
	logic carry_out;
	logic [7:0] v;

	// ************************************************************
	// shift and flag update
	// ************************************************************
	always_comb begin
		v = value;
		carry_out = flags[FLAG_C];
		case (op)
			shift_left_logical: begin
				v = {value[6:0], 1'b0};
				carry_out = value[7];
			end
			rotate_left_via_carry: begin
				v = {value[6:0], flags[FLAG_C]};
				carry_out = value[7];
			end
			shift_right_logical: begin
				v = {1'b0, value[7:1]};
				carry_out = value[0];
			end
			rotate_right_via_carry: begin
				v = {flags[FLAG_C], value[7:1]};
				carry_out = value[0];
			end
			shift_right_arith: begin
				v = {value[7], value[7:1]};
				carry_out = value[0];
			end
			default: begin
				v = value;
				carry_out = flags[FLAG_C];
			end
		endcase
		// only z c n v move; s is left alone
		res.value = v;
		res.flags = flags;
		res.flags[FLAG_C] = carry_out;
		res.flags[FLAG_Z] = (v == 8'h00);
		res.flags[FLAG_N] = v[7];
		res.flags[FLAG_V] = v[7] ^ carry_out;
	end
endmodule : shift_unit

/* verif/exec_slice_sva.sv */
module exec_slice_sva
	import exec_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire bus_req_t req,
	input wire logic [7:0] rdata,
	input wire logic busy,
	input wire logic done
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// timing checks
	// ************************************************************
	logic go;
	logic [4:0] code;
	assign code = req.wdata[4:0];
	assign go = req.wr && req.addr == OFS_OP && !busy;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence one_s;
		busy ##1 !busy && done;
	endsequence
	sequence two_s;
		busy [*2] ##1 !busy && done;
	endsequence
	shift_one_cycle_a: assert property (
		go && code >= 5'h19 && code <= OP_LAST |=> one_s)
		else $error("shift length wrong");
	io_two_cycle_a: assert property (
		go && (code == 5'h17 || code == 5'h18) |=> two_s)
		else $error("io bit op length wrong");
	branch_len_a: assert property (
		go && code >= 5'h03 && code <= 5'h16
		|=> busy ##[1:2] (!busy && done)) else $error("branch length wrong");
	skip_len_a: assert property (
		go && code <= 5'h02 |=> busy ##[1:3] (!busy && done))
		else $error("skip length wrong");
	bad_op_a: assert property (go && code > OP_LAST |=> !busy)
		else $error("bad op started");
	done_pulse_a: assert property (done |=> !done)
		else $error("done longer than one cycle");
	done_follows_a: assert property (done |-> !busy && $past(busy))
		else $error("done without run");
	unmapped_zero_a: assert property (
		req.rd && req.addr >= 8'h08 && req.addr < 8'h40 |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	stat_busy_a: assert property (
		req.rd && req.addr == OFS_STAT |=> rdata[0] == $past(busy))
		else $error("status busy bit wrong");
endmodule : exec_slice_sva

bind exec_slice exec_slice_sva chk (.clk(clk), .rst(rst), .req(req),
	.rdata(rdata), .busy(busy), .done(done));

/* verif/tb.sv */
`define CHK(nm, e, s) \
	begin \
		num_checks++; \
		if ((s) !== (e)) begin \
			err_total++; \
			$display("MISMATCH %s exp %0h got %0h", nm, e, s); \
		end \
	end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import exec_pkg::*;
	// ************************************************************
	// bench
	// ************************************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	bus_req_t req = '0;
	logic [7:0] rdata;
	logic busy;
	logic done;
	int err_total = 0;
	int num_checks = 0;
	int op;
	int cyc;
	int n;
	logic [31:0] seed = 32'h6213;
	logic [31:0] r1;
	logic [31:0] r2;
	logic [15:0] pc;
	logic [15:0] npc;
	logic [7:0] fl;
	logic [7:0] nf;
	logic [7:0] v;
	logic [7:0] res;
	logic [7:0] vio;
	logic [7:0] rv;
	logic [6:0] k;
	logic [5:0] sel;
	logic [2:0] b;
	logic tw;
	logic t;
	logic co;
	logic [7:0] ra [7] = '{OFS_PC_LO, OFS_PC_HI, OFS_FLAGS, OFS_STAT,
		8'h85, 8'h20, 8'hc0};

	always #4 clk = ~clk;

	exec_slice dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
		.busy(busy), .done(done));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// strobe left up on purpose: the next task overwrites it once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= {a, d, 1'b1, 1'b0};
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		req <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req <= '0;
		#1 d = rdata;
		@(posedge clk);
	endtask : rd

	task automatic ck(input logic [7:0] a, input logic [7:0] e);
		rd(a, rv);
		`CHK($sformatf("reg_%h", a), e, rv)
	endtask : ck

	// poll after the edge lands, done stands one cycle only
	task automatic go(input logic [7:0] o, output int c);
		wr(OFS_OP, o);
		req <= '0;
		c = 0;
		do begin
			@(posedge clk);
			#1;
			c++;
		end while (done !== 1'b1 && c < 8);
		@(posedge clk);
	endtask : go

	task automatic model();
		npc = pc + 16'h0001;
		cyc = 1;
		nf = fl;
		res = v;
		vio = v;
		co = fl[FLAG_C];
		case (op)
			0, 1, 2: t = v[b];
			3, 4: t = fl[b];
			5, 6: t = fl[FLAG_Z];
			7, 8, 9, 10: t = fl[FLAG_C];
			11, 12: t = fl[FLAG_N];
			13, 14: t = fl[FLAG_N] ^ fl[FLAG_V];
			15, 16: t = fl[FLAG_H];
			17, 18: t = fl[FLAG_T];
			19, 20: t = fl[FLAG_V];
			21, 22: t = fl[FLAG_I];
			default: t = 1'b0;
		endcase
		if (op inside {1, 4, 6, 8, 9, 12, 13, 16, 18, 20, 22})
			t = !t;
		if (op <= 2 && t) begin
			npc = pc + 16'h0002 + 16'(tw);
			cyc = 2 + tw;
		end
		if (op >= 3 && op <= 22 && t) begin
			npc = pc + 16'h0001 + {{9{k[6]}}, k};
			cyc = 2;
		end
		if (op == 23 || op == 24) begin
			vio[b] = (op == 23);
			cyc = 2;
		end
		case (op)
			25: {co, res} = {v, 1'b0};
			26: {res, co} = {1'b0, v};
			27: {co, res} = {v, fl[FLAG_C]};
			28: {res, co} = {fl[FLAG_C], v};
			29: {res, co} = {v[7], v};
			default: ;
		endcase
		if (op >= 25) begin
			nf[FLAG_C] = co;
			nf[FLAG_Z] = (res == 8'h00);
			nf[FLAG_N] = res[7];
			nf[FLAG_V] = res[7] ^ co;
		end
	endtask : model

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	initial begin
		#100000;
		err_total++;
		wrap_up();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		foreach (ra[i])
			ck(ra[i], 8'h00);
		for (int i = 0; i < 90; i++) begin
			op = i % 30;
			r1 = rnd();
			r2 = rnd();
			fl = r1[31:24];
			sel = r1[5:0];
			b = r1[8:6];
			k = r1[15:9];
			tw = r1[16];
			pc = r2[15:0];
			v = r2[23:16];
			// last pass: every skip taken over a two-word instruction
			if (i >= 60) begin
				tw = 1'b1;
				v[b] = (op != 1);
			end
			wr(OFS_FLAGS, fl);
			wr(OFS_SEL, {2'b00, sel});
			wr(OFS_BIT, {5'h00, b});
			wr(OFS_DISP, {1'b0, k});
			wr(OFS_PC_LO, pc[7:0]);
			wr(OFS_PC_HI, pc[15:8]);
			wr(OFS_GPR_BASE + {3'b000, sel[4:0]}, v);
			wr(OFS_IO_BASE + {2'b00, sel}, v);
			go({tw, 2'b00, 5'(op)}, n);
			model();
			`CHK("cycles", cyc, n)
			ck(OFS_PC_LO, npc[7:0]);
			ck(OFS_PC_HI, npc[15:8]);
			ck(OFS_FLAGS, nf);
			ck(OFS_GPR_BASE + {3'b000, sel[4:0]}, res);
			ck(OFS_IO_BASE + {2'b00, sel}, vio);
			rd(OFS_STAT, rv);
			`CHK("stat", {cyc[1:0], 1'b0}, rv[2:0])
		end
		wr(OFS_OP, 8'h1f);
		rd(OFS_STAT, rv);
		`CHK("bad_op", 1'b0, rv[0])
		wr(OFS_OP, 8'h17);
		wr(OFS_FLAGS, ~nf);
		ck(OFS_FLAGS, nf);
		repeat (4) @(posedge clk);
		wrap_up();
	end
endmodule : tb
